// ===== design/maeh_pkg.sv
// shared constants for the memory access error handler
package maeh_pkg;
  // widths
  localparam int ADDR_W = 32;
  localparam int AGENT_W = 2;
  localparam int TYPE_W = 4;
  // logged type codes
  localparam logic [3:0] TYPE_INSTR_COUPLED_PORT_OTP_RD = 4'h6;
  localparam logic [3:0] TYPE_INSTR_COUPLED_PORT_FLASH_RD = 4'h7;
  localparam logic [3:0] TYPE_AHB_FLASH_RD = 4'h2;
  localparam logic [3:0] TYPE_AHB_FLASH_WR = 4'h3;
  localparam logic [3:0] TYPE_AHB_PROG_DIS = 4'h4;
  localparam logic [3:0] TYPE_SRAM_RD = 4'h0;
  localparam logic [3:0] TYPE_SRAM_WR = 4'h1;
  // agent code of the cpu on its coupled ports
  localparam logic [1:0] AGENT_CPU = 2'h0;
  // address masks for quadword and doubleword logging
  localparam logic [31:0] QW_MASK = 32'hFFFFFFF8;
  localparam logic [31:0] DW_MASK = 32'hFFFFFFFC;
  // fill pattern for prefetch spills into reserved space
  localparam logic [63:0] FILL_C = 64'hCCCCCCCCCCCCCCCC;
  // reserved ranges reached by prefetch spill
  localparam logic [31:0] IROM_RSV_LO = 32'h00002000;
  localparam logic [31:0] IROM_RSV_HI = 32'h0007FFFF;
  localparam logic [31:0] IRAM_RSV_LO = 32'h00188000;
  localparam logic [31:0] IRAM_RSV_HI = 32'h001FFFFF;
  localparam logic [31:0] DRAM_RSV_LO = 32'h00282000;
  localparam logic [31:0] DRAM_RSV_HI = 32'h002FFFFF;
  // reset values
  localparam logic [31:0] DUMMY_RST = 32'h00000000;
endpackage

// ===== design/maeh_dummy_reg.sv
// lockable dummy-data register
`timescale 1ns/1ps
`default_nettype none
module maeh_dummy_reg
  import maeh_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // programming
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic lock_i,
  // state
  output logic [31:0] value_o,
  output logic locked_o
);
  // lock is sticky; only a warm reset reopens the register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      locked_o <= 1'b0;
    end else if (lock_i) begin
      locked_o <= 1'b1;
    end
  end

  // writes are ignored once locked
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      value_o <= DUMMY_RST;
    end else if (wr_i && !locked_o) begin
      value_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// ===== design/maeh_viol_log.sv
// violation log: holds first violation until read, pulses an event
`timescale 1ns/1ps
`default_nettype none
module maeh_viol_log
  import maeh_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // violation in
  input wire logic ev_i,
  input wire logic [AGENT_W-1:0] agent_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [TYPE_W-1:0] type_i,
  input wire logic rd_ack_i,
  // log out
  output logic valid_o,
  output logic [AGENT_W-1:0] agent_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [TYPE_W-1:0] type_o,
  output logic irq_o
);
  logic take;

  // capture when empty, or when software reads in the same cycle: set wins
  assign take = ev_i && (!valid_o || rd_ack_i);

  // valid flag
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
    end else if (take) begin
      valid_o <= 1'b1;
    end else if (rd_ack_i) begin
      valid_o <= 1'b0;
    end
  end

  // logged fields stay frozen until read
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      agent_o <= '0;
      addr_o <= '0;
      type_o <= '0;
    end else if (take) begin
      agent_o <= agent_i;
      addr_o <= addr_i;
      type_o <= type_i;
    end
  end

  // one pulse per violation, even when the log is already full
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ev_i;
    end
  end
endmodule
`default_nettype wire

// ===== design/maeh_top.sv
// error and boundary handling for flash and sram controllers
// How it works
// - instr_coupled_port out-of-range read: no event, dummy value in both halves
// - instr_coupled_port violation: interrupt, log agent, quadword address, type 6 or 7
// - simultaneous flash violations: the AHB one is logged
// - AHB outside flash never reaches here; no event, no log
// - AHB flash read violation: interrupt, doubleword log, dummy value once
// - AHB plain write to flash: interrupt, doubleword log, data discarded
// - program request with writes disabled: interrupt, log, no program start
// - program address outside OTP and main flash: no start, no event
// - data_coupled_port out-of-range read: no event, dummy value in both halves
// - data_coupled_port out-of-range write: forwarded with all strobes inactive
// - data_coupled_port violations: interrupt, quadword log, dummy read or dead strobes
// - simultaneous sram violations: the AHB one is logged
// - AHB outside sram never reaches here; no event, no log
// - AHB sram violations: interrupt, quadword log, dummy read or dead strobes
// - reset-vector prefetch wrap to 0x0/0x8/0x10 served from OTP, no error
// - instruction spill into reserved space returns all-Cs, no error
// - data ROM spill goes over AHB; the fabric answers with an error
// - data RAM spill into reserved space returns all-Cs; fabric also errors
// - prefetch into a protected sram region is flagged as a violation
// - dummy data is programmable and locks until warm reset
`timescale 1ns/1ps
`default_nettype none
module maeh_top
  import maeh_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // dummy-data programming
  input wire logic dummy_wr_i,
  input wire logic [31:0] dummy_wdata_i,
  input wire logic dummy_lock_i,
  output logic [31:0] dummy_value_o,
  output logic dummy_locked_o,
  // instruction coupled port (flash)
  input wire logic instr_coupled_port_req_i,
  input wire logic [maeh_pkg::ADDR_W-1:0] instr_coupled_port_addr_i,
  input wire logic instr_coupled_port_oor_i,
  input wire logic instr_coupled_port_viol_i,
  input wire logic instr_coupled_port_otp_i,
  input wire logic [63:0] flash_instr_coupled_port_rdata_i,
  output logic [63:0] instr_coupled_port_rdata_o,
  // ahb toward flash
  input wire logic fahb_req_i,
  input wire logic fahb_write_i,
  input wire logic fahb_prog_i,
  input wire logic [maeh_pkg::ADDR_W-1:0] fahb_addr_i,
  input wire logic [maeh_pkg::AGENT_W-1:0] fahb_agent_i,
  input wire logic fahb_rd_viol_i,
  input wire logic fahb_prog_dis_i,
  input wire logic fahb_prog_oor_i,
  input wire logic [31:0] flash_ahb_rdata_i,
  output logic [31:0] fahb_rdata_o,
  output logic fahb_wr_drop_o,
  output logic prog_start_o,
  // data coupled port (sram)
  input wire logic data_coupled_port_req_i,
  input wire logic data_coupled_port_write_i,
  input wire logic [maeh_pkg::ADDR_W-1:0] data_coupled_port_addr_i,
  input wire logic data_coupled_port_oor_i,
  input wire logic data_coupled_port_viol_i,
  input wire logic [7:0] data_coupled_port_byte_lane_strobes_i,
  input wire logic [63:0] sram_data_coupled_port_rdata_i,
  output logic [63:0] data_coupled_port_rdata_o,
  output logic [7:0] sram_data_coupled_port_byte_lane_strobes_o,
  output logic sram_data_coupled_port_wr_o,
  // ahb toward sram
  input wire logic sahb_req_i,
  input wire logic sahb_write_i,
  input wire logic [maeh_pkg::ADDR_W-1:0] sahb_addr_i,
  input wire logic [maeh_pkg::AGENT_W-1:0] sahb_agent_i,
  input wire logic sahb_viol_i,
  input wire logic [3:0] sahb_byte_lane_strobes_i,
  input wire logic [31:0] sram_ahb_rdata_i,
  output logic [31:0] sahb_rdata_o,
  output logic [3:0] sram_ahb_byte_lane_strobes_o,
  output logic sram_ahb_wr_o,
  // flash log
  input wire logic flash_log_rd_i,
  output logic flash_log_valid_o,
  output logic [maeh_pkg::AGENT_W-1:0] flash_log_agent_o,
  output logic [maeh_pkg::ADDR_W-1:0] flash_log_addr_o,
  output logic [maeh_pkg::TYPE_W-1:0] flash_log_type_o,
  output logic flash_irq_o,
  // sram log
  input wire logic sram_log_rd_i,
  output logic sram_log_valid_o,
  output logic [maeh_pkg::AGENT_W-1:0] sram_log_agent_o,
  output logic [maeh_pkg::ADDR_W-1:0] sram_log_addr_o,
  output logic [maeh_pkg::TYPE_W-1:0] sram_log_type_o,
  output logic sram_irq_o
);
  import maeh_pkg::*;

  logic [31:0] dummy;
  logic i_rsv, d_rsv;
  logic i_ev, fa_rd_ev, fa_wr_ev, fa_pd_ev, fa_ev, f_ev;
  logic [AGENT_W-1:0] f_agent;
  logic [ADDR_W-1:0] f_addr;
  logic [TYPE_W-1:0] f_type;
  logic d_ev, sa_ev, s_ev;
  logic [AGENT_W-1:0] s_agent;
  logic [ADDR_W-1:0] s_addr;
  logic [TYPE_W-1:0] s_type;

  // dummy-data register, sealed by its own sticky lock from dummy_lock_i
  maeh_dummy_reg u_dummy (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .wr_i(dummy_wr_i),
    .wdata_i(dummy_wdata_i),
    .lock_i(dummy_lock_i),
    .value_o(dummy),
    .locked_o(dummy_locked_o)
  );
  assign dummy_value_o = dummy;

  // reserved spill ranges; OTP wrap addresses 0x0..0x10 stay in range
  // so a wrap after the reset vector reads real otp code and stays silent
  assign i_rsv = ((instr_coupled_port_addr_i >= IROM_RSV_LO) &&
                  (instr_coupled_port_addr_i <= IROM_RSV_HI)) ||
                 ((instr_coupled_port_addr_i >= IRAM_RSV_LO) &&
                  (instr_coupled_port_addr_i <= IRAM_RSV_HI));
  // spills past data rom or data ram reach the fabric, which answers with its own
  // error; here they only must not raise a second, spurious violation
  assign d_rsv = (sahb_addr_i >= DRAM_RSV_LO) && (sahb_addr_i <= DRAM_RSV_HI);

  // flash events; reserved spill and out-of-range never raise one
  // the oor and viol flags come from upstream decoders and are trusted as given;
  // when both are set the range check wins, so an unmapped address never logs
  assign i_ev = instr_coupled_port_req_i && instr_coupled_port_viol_i &&
                !instr_coupled_port_oor_i && !i_rsv;
  assign fa_rd_ev = fahb_req_i && !fahb_write_i && fahb_rd_viol_i;
  assign fa_wr_ev = fahb_req_i && fahb_write_i && !fahb_prog_i;
  assign fa_pd_ev = fahb_req_i && fahb_prog_i && fahb_prog_dis_i && !fahb_prog_oor_i;
  assign fa_ev = fa_rd_ev || fa_wr_ev || fa_pd_ev;
  assign f_ev = fa_ev || i_ev;

  // ahb wins when both flash ports violate together
  always_comb begin
    f_agent = AGENT_CPU;
    f_addr = instr_coupled_port_addr_i & QW_MASK;
    f_type = instr_coupled_port_otp_i ? TYPE_INSTR_COUPLED_PORT_OTP_RD : TYPE_INSTR_COUPLED_PORT_FLASH_RD;
    if (fa_ev) begin
      f_agent = fahb_agent_i;
      f_addr = fahb_addr_i & DW_MASK;
      if (fa_pd_ev) begin
        f_type = TYPE_AHB_PROG_DIS;
      end else if (fa_wr_ev) begin
        f_type = TYPE_AHB_FLASH_WR;
      end else begin
        f_type = TYPE_AHB_FLASH_RD;
      end
    end
  end

  // the log keeps the oldest violation; later ones still pulse the interrupt but
  // their details are lost until software has read the held entry
  maeh_viol_log u_flash_log (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ev_i(f_ev),
    .agent_i(f_agent),
    .addr_i(f_addr),
    .type_i(f_type),
    .rd_ack_i(flash_log_rd_i),
    .valid_o(flash_log_valid_o),
    .agent_o(flash_log_agent_o),
    .addr_o(flash_log_addr_o),
    .type_o(flash_log_type_o),
    .irq_o(flash_irq_o)
  );

  // instruction read data: Cs for spill, dummy doubled for oor or violation
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      instr_coupled_port_rdata_o <= '0;
    end else if (instr_coupled_port_req_i) begin
      if (i_rsv) begin
        instr_coupled_port_rdata_o <= FILL_C;
      end else if (instr_coupled_port_oor_i || instr_coupled_port_viol_i) begin
        instr_coupled_port_rdata_o <= {dummy, dummy};
      end else begin
        instr_coupled_port_rdata_o <= flash_instr_coupled_port_rdata_i;
      end
    end
  end

  // ahb flash read data: dummy once on violation
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fahb_rdata_o <= '0;
    end else if (fahb_req_i && !fahb_write_i) begin
      fahb_rdata_o <= fahb_rd_viol_i ? dummy : flash_ahb_rdata_i;
    end
  end

  // write drop and program start
  // a blocked program never pulses prog_start_o, so the sequencer cannot begin
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fahb_wr_drop_o <= 1'b0;
      prog_start_o <= 1'b0;
    end else begin
      fahb_wr_drop_o <= fa_wr_ev;
      prog_start_o <= fahb_req_i && fahb_prog_i && !fahb_prog_dis_i &&
                      !fahb_prog_oor_i;
    end
  end

  // sram events; the two ports are not expected to violate together, but if they do the ahb one is logged
  assign d_ev = data_coupled_port_req_i && data_coupled_port_viol_i &&
                !data_coupled_port_oor_i;
  assign sa_ev = sahb_req_i && sahb_viol_i && !d_rsv;
  assign s_ev = d_ev || sa_ev;

  // sram log fields; with no priority needed the ahb side simply overrides
  always_comb begin
    s_agent = AGENT_CPU;
    s_addr = data_coupled_port_addr_i & QW_MASK;
    s_type = data_coupled_port_write_i ? TYPE_SRAM_WR : TYPE_SRAM_RD;
    if (sa_ev) begin
      s_agent = sahb_agent_i;
      s_addr = sahb_addr_i & QW_MASK;
      s_type = sahb_write_i ? TYPE_SRAM_WR : TYPE_SRAM_RD;
    end
  end

  maeh_viol_log u_sram_log (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ev_i(s_ev),
    .agent_i(s_agent),
    .addr_i(s_addr),
    .type_i(s_type),
    .rd_ack_i(sram_log_rd_i),
    .valid_o(sram_log_valid_o),
    .agent_o(sram_log_agent_o),
    .addr_o(sram_log_addr_o),
    .type_o(sram_log_type_o),
    .irq_o(sram_irq_o)
  );

  // data port writes: forwarded to keep the protocol, dead strobes keep sram intact
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sram_data_coupled_port_byte_lane_strobes_o <= '0;
      sram_data_coupled_port_wr_o <= 1'b0;
    end else begin
      sram_data_coupled_port_wr_o <= data_coupled_port_req_i && data_coupled_port_write_i;
      sram_data_coupled_port_byte_lane_strobes_o <= '0;
      if (data_coupled_port_req_i && data_coupled_port_write_i) begin
        if (!(data_coupled_port_oor_i || data_coupled_port_viol_i)) begin
          sram_data_coupled_port_byte_lane_strobes_o <= data_coupled_port_byte_lane_strobes_i;
        end
      end
    end
  end

  // data port reads: the sram read still runs, dummy doubled overrides it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_coupled_port_rdata_o <= '0;
    end else if (data_coupled_port_req_i && !data_coupled_port_write_i) begin
      if (data_coupled_port_oor_i || data_coupled_port_viol_i) begin
        data_coupled_port_rdata_o <= {dummy, dummy};
      end else begin
        data_coupled_port_rdata_o <= sram_data_coupled_port_rdata_i;
      end
    end
  end

  // ahb sram writes: dead strobes on violation, reserved spill never forwarded
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sram_ahb_byte_lane_strobes_o <= '0;
      sram_ahb_wr_o <= 1'b0;
    end else begin
      sram_ahb_wr_o <= sahb_req_i && sahb_write_i && !d_rsv;
      sram_ahb_byte_lane_strobes_o <= '0;
      if (sahb_req_i && sahb_write_i && !sahb_viol_i && !d_rsv) begin
        sram_ahb_byte_lane_strobes_o <= sahb_byte_lane_strobes_i;
      end
    end
  end

  // ahb sram reads: Cs for reserved spill, dummy once on violation
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sahb_rdata_o <= '0;
    end else if (sahb_req_i && !sahb_write_i) begin
      if (d_rsv) begin
        sahb_rdata_o <= FILL_C[31:0];
      end else if (sahb_viol_i) begin
        sahb_rdata_o <= dummy;
      end else begin
        sahb_rdata_o <= sram_ahb_rdata_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/maeh_mem_model.sv
// memory-side partner: flash and sram read data for the error handler
`timescale 1ns/1ps
`default_nettype none
module maeh_mem_model (
  // request addresses
  input wire logic [31:0] ia_i,
  input wire logic [31:0] fa_i,
  input wire logic [31:0] da_i,
  input wire logic [31:0] sa_i,
  // read data
  output logic [63:0] irdata_o,
  output logic [31:0] frdata_o,
  output logic [63:0] drdata_o,
  output logic [31:0] srdata_o
);
  // contents follow the address, so raw data leaking past a violation is visible
  assign irdata_o = {ia_i, ~ia_i};
  assign frdata_o = ~fa_i;
  assign drdata_o = {~da_i, da_i};
  assign srdata_o = sa_i ^ 32'h5A5A5A5A;
endmodule
`default_nettype wire

// ===== tb/maeh_chk.sv
// assertions on the error handler ports
`timescale 1ns/1ps
`default_nettype none
module maeh_chk
  import maeh_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // watched ports
  input wire logic [31:0] dummy_value_o,
  input wire logic instr_coupled_port_req_i,
  input wire logic instr_coupled_port_oor_i,
  input wire logic instr_coupled_port_viol_i,
  input wire logic [63:0] instr_coupled_port_rdata_o,
  input wire logic fahb_req_i,
  input wire logic fahb_write_i,
  input wire logic fahb_prog_i,
  input wire logic fahb_rd_viol_i,
  input wire logic fahb_prog_dis_i,
  input wire logic fahb_prog_oor_i,
  input wire logic [31:0] fahb_rdata_o,
  input wire logic fahb_wr_drop_o,
  input wire logic prog_start_o,
  input wire logic data_coupled_port_req_i,
  input wire logic data_coupled_port_write_i,
  input wire logic data_coupled_port_oor_i,
  input wire logic data_coupled_port_viol_i,
  input wire logic [7:0] sram_data_coupled_port_byte_lane_strobes_o,
  input wire logic sram_data_coupled_port_wr_o,
  input wire logic sahb_req_i,
  input wire logic sahb_write_i,
  input wire logic sahb_viol_i,
  input wire logic [3:0] sram_ahb_byte_lane_strobes_o,
  input wire logic sram_ahb_wr_o,
  input wire logic flash_log_rd_i,
  input wire logic flash_log_valid_o,
  input wire logic [ADDR_W-1:0] flash_log_addr_o,
  input wire logic flash_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a request step that triggers a check, and the flash event that checks expect
  sequence instr_coupled_port_oor_s;
    instr_coupled_port_req_i && instr_coupled_port_oor_i && !fahb_req_i;
  endsequence
  sequence fahb_ev_s;
    flash_irq_o && flash_log_valid_o;
  endsequence
  instr_coupled_port_oor_a:
    assert property (instr_coupled_port_oor_s |=> !flash_irq_o &&
      instr_coupled_port_rdata_o == {2{$past(dummy_value_o)}}) else $error("instr_coupled_port oor read");
  instr_coupled_port_viol_a:
    assert property (instr_coupled_port_req_i && instr_coupled_port_viol_i &&
      !instr_coupled_port_oor_i |=> fahb_ev_s) else $error("instr_coupled_port violation not raised");
  fahb_rd_a:
    assert property (fahb_req_i && !fahb_write_i && fahb_rd_viol_i |=> fahb_ev_s and
      fahb_rdata_o == $past(dummy_value_o)) else $error("ahb flash read violation");
  wr_drop_a:
    assert property (fahb_req_i && fahb_write_i && !fahb_prog_i |=> fahb_wr_drop_o ##0
      fahb_ev_s) else $error("ahb flash write not dropped");
  prog_block_a:
    assert property (fahb_req_i && fahb_prog_i && (fahb_prog_dis_i || fahb_prog_oor_i)
      |=> !prog_start_o) else $error("blocked program started");
  data_coupled_port_wr_a:
    assert property (data_coupled_port_req_i && data_coupled_port_write_i &&
      (data_coupled_port_oor_i || data_coupled_port_viol_i) |=> sram_data_coupled_port_wr_o &&
      sram_data_coupled_port_byte_lane_strobes_o == 8'h00) else $error("data_coupled_port write strobes live");
  sahb_wr_a:
    assert property (sahb_req_i && sahb_write_i && sahb_viol_i |=> sram_ahb_wr_o &&
      sram_ahb_byte_lane_strobes_o == 4'h0) else $error("ahb sram write strobes live");
  log_hold_a:
    assert property (flash_log_valid_o && !flash_log_rd_i |=> flash_log_valid_o &&
      $stable(flash_log_addr_o)) else $error("flash log not held");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking testbench for the memory access error handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  import maeh_pkg::*;
  localparam logic [31:0] D = 32'hA5C31E0F;
  logic clk_i, resetn_i, dummy_wr_i, dummy_lock_i, dummy_locked_o;
  logic [31:0] dummy_wdata_i, dummy_value_o, flash_ahb_rdata_i, fahb_rdata_o;
  logic instr_coupled_port_req_i, instr_coupled_port_oor_i, instr_coupled_port_viol_i;
  logic instr_coupled_port_otp_i, fahb_req_i, fahb_write_i, fahb_prog_i, fahb_rd_viol_i;
  logic fahb_prog_dis_i, fahb_prog_oor_i, fahb_wr_drop_o, prog_start_o, sram_irq_o;
  logic [31:0] instr_coupled_port_addr_i, fahb_addr_i, data_coupled_port_addr_i, sahb_addr_i;
  logic [63:0] flash_instr_coupled_port_rdata_i, instr_coupled_port_rdata_o, sram_data_coupled_port_rdata_i;
  logic [63:0] data_coupled_port_rdata_o;
  logic [1:0] fahb_agent_i, sahb_agent_i, flash_log_agent_o, sram_log_agent_o;
  logic data_coupled_port_req_i, data_coupled_port_write_i, data_coupled_port_oor_i;
  logic data_coupled_port_viol_i, sram_data_coupled_port_wr_o, sahb_req_i, sahb_write_i, sahb_viol_i;
  logic [7:0] data_coupled_port_byte_lane_strobes_i, sram_data_coupled_port_byte_lane_strobes_o;
  logic [3:0] sahb_byte_lane_strobes_i, sram_ahb_byte_lane_strobes_o;
  logic [31:0] sram_ahb_rdata_i, sahb_rdata_o, flash_log_addr_o, sram_log_addr_o;
  logic sram_ahb_wr_o, flash_log_rd_i, flash_log_valid_o, flash_irq_o;
  logic sram_log_rd_i, sram_log_valid_o;
  logic [3:0] flash_log_type_o, sram_log_type_o;
  int errors, check_count;
  maeh_top dut (.*);
  maeh_mem_model mem (.ia_i(instr_coupled_port_addr_i), .fa_i(fahb_addr_i),
    .da_i(data_coupled_port_addr_i), .sa_i(sahb_addr_i), .irdata_o(flash_instr_coupled_port_rdata_i),
    .frdata_o(flash_ahb_rdata_i), .drdata_o(sram_data_coupled_port_rdata_i), .srdata_o(sram_ahb_rdata_i));
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // request and flag inputs drop after one cycle so no request is taken twice
  task automatic clr;
    {instr_coupled_port_req_i, instr_coupled_port_oor_i, instr_coupled_port_viol_i,
     instr_coupled_port_otp_i, fahb_req_i, fahb_write_i, fahb_prog_i, fahb_rd_viol_i,
     fahb_prog_dis_i, fahb_prog_oor_i, data_coupled_port_req_i, data_coupled_port_write_i,
     data_coupled_port_oor_i, data_coupled_port_viol_i, sahb_req_i, sahb_write_i,
     sahb_viol_i, flash_log_rd_i, sram_log_rd_i, dummy_wr_i, dummy_lock_i} <= '0;
  endtask
  task automatic fire;
    @(posedge clk_i);
    clr;
    #1;
  endtask
  task automatic rd_logs;
    @(posedge clk_i);
    flash_log_rd_i <= 1'b1;
    sram_log_rd_i <= 1'b1;
    fire;
  endtask
  task automatic ireq(input logic [31:0] a, input logic [2:0] f);
    @(posedge clk_i);
    instr_coupled_port_req_i <= 1'b1;
    instr_coupled_port_addr_i <= a;
    {instr_coupled_port_oor_i, instr_coupled_port_viol_i, instr_coupled_port_otp_i} <= f;
    fire;
  endtask
  task automatic freq(input logic [31:0] a, input logic [4:0] f);
    @(posedge clk_i);
    fahb_req_i <= 1'b1;
    fahb_addr_i <= a;
    {fahb_write_i, fahb_prog_i, fahb_rd_viol_i, fahb_prog_dis_i, fahb_prog_oor_i} <= f;
    fire;
  endtask
  task automatic dreq(input logic [31:0] a, input logic [2:0] f);
    @(posedge clk_i);
    data_coupled_port_req_i <= 1'b1;
    data_coupled_port_addr_i <= a;
    {data_coupled_port_write_i, data_coupled_port_oor_i, data_coupled_port_viol_i} <= f;
    fire;
  endtask
  task automatic sreq(input logic [31:0] a, input logic [1:0] f);
    @(posedge clk_i);
    sahb_req_i <= 1'b1;
    sahb_addr_i <= a;
    {sahb_write_i, sahb_viol_i} <= f;
    fire;
  endtask
  task automatic t_dummy;
    @(posedge clk_i);
    dummy_wdata_i <= D;
    dummy_wr_i <= 1'b1;
    dummy_lock_i <= 1'b1;
    fire;
    @(posedge clk_i);
    dummy_wdata_i <= 32'h12345678;
    dummy_wr_i <= 1'b1;
    fire;
    `CHK({dummy_locked_o, dummy_value_o}, {1'b1, D})
    $display("dummy lock test done");
  endtask
  task automatic t_instr_coupled_port;
    ireq(32'h00F00004, 3'b110);
    `CHK({flash_irq_o, instr_coupled_port_rdata_o}, {1'b0, D, D})
    ireq(32'h00001234, 3'b011);
    `CHK({flash_irq_o, flash_log_agent_o, flash_log_type_o}, {1'b1, AGENT_CPU, 4'h6})
    `CHK(flash_log_addr_o, 32'h00001230)
    rd_logs;
    ireq(32'h00180ABC, 3'b010);
    `CHK({flash_log_type_o, flash_log_addr_o}, {4'h7, 32'h00180AB8})
    rd_logs;
    for (int i = 0; i < 3; i++) begin
      ireq(32'(8 * i), 3'b000);
      `CHK({flash_irq_o, instr_coupled_port_rdata_o}, {1'b0, 32'(8 * i), ~32'(8 * i)})
    end
    ireq(32'h00002000, 3'b000);
    `CHK({flash_irq_o, instr_coupled_port_rdata_o}, {1'b0, FILL_C})
    ireq(32'h00188000, 3'b000);
    `CHK({flash_irq_o, instr_coupled_port_rdata_o}, {1'b0, FILL_C})
    $display("instr port test done");
  endtask
  task automatic t_fahb;
    @(posedge clk_i);
    {instr_coupled_port_req_i, instr_coupled_port_viol_i, fahb_req_i, fahb_rd_viol_i} <= '1;
    fahb_addr_i <= 32'h00180106;
    instr_coupled_port_addr_i <= 32'h00000100;
    fire;
    `CHK({flash_irq_o, flash_log_type_o, flash_log_addr_o}, {1'b1, 4'h2, 32'h00180104})
    `CHK({fahb_rdata_o, flash_log_agent_o}, {D, 2'h1})
    @(posedge clk_i);
    #1;
    `CHK(flash_irq_o, 1'b0)
    rd_logs;
    freq(32'h00180022, 5'b10000);
    `CHK({fahb_wr_drop_o, flash_irq_o, flash_log_type_o}, {1'b1, 1'b1, 4'h3})
    rd_logs;
    freq(32'h00180033, 5'b11010);
    `CHK({prog_start_o, flash_irq_o, flash_log_type_o}, {1'b0, 1'b1, 4'h4})
    `CHK(flash_log_addr_o, 32'h00180030)
    rd_logs;
    freq(32'h00500000, 5'b11001);
    `CHK({prog_start_o, flash_irq_o, flash_log_valid_o}, 3'b000)
    freq(32'h00180040, 5'b11000);
    `CHK({prog_start_o, flash_irq_o}, 2'b10)
    $display("ahb flash test done");
  endtask
  task automatic t_sram;
    dreq(32'h0FF00000, 3'b010);
    `CHK({sram_irq_o, data_coupled_port_rdata_o}, {1'b0, D, D})
    dreq(32'h0FF00000, 3'b110);
    `CHK({sram_irq_o, sram_data_coupled_port_wr_o, sram_data_coupled_port_byte_lane_strobes_o}, {2'b01, 8'h00})
    dreq(32'h00280A0C, 3'b101);
    `CHK({sram_irq_o, sram_data_coupled_port_byte_lane_strobes_o, sram_log_type_o}, {1'b1, 8'h00, 4'h1})
    `CHK({sram_log_agent_o, sram_log_addr_o}, {AGENT_CPU, 32'h00280A08})
    rd_logs;
    dreq(32'h00280010, 3'b100);
    `CHK({sram_irq_o, sram_data_coupled_port_wr_o, sram_data_coupled_port_byte_lane_strobes_o}, {2'b01, 8'hFF})
    sreq(32'h00280104, 2'b01);
    `CHK({sram_irq_o, sahb_rdata_o, sram_log_type_o}, {1'b1, D, 4'h0})
    sreq(32'h00280208, 2'b11);
    `CHK({sram_irq_o, sram_ahb_wr_o, sram_ahb_byte_lane_strobes_o}, {2'b11, 4'h0})
    `CHK({sram_log_agent_o, sram_log_addr_o}, {2'h2, 32'h00280100})
    rd_logs;
    `CHK(sram_log_valid_o, 1'b0)
    sreq(32'h00282000, 2'b00);
    `CHK({sram_irq_o, sahb_rdata_o}, {1'b0, 32'hCCCCCCCC})
    sreq(32'h00280000, 2'b00);
    `CHK({sram_irq_o, sahb_rdata_o}, {1'b0, 32'h00280000 ^ 32'h5A5A5A5A})
    $display("sram test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    wrap_up;
  end
  // reset, then the scenarios in turn
  initial begin
    resetn_i = 1'b0;
    {dummy_wdata_i, instr_coupled_port_addr_i, fahb_addr_i} = '0;
    {data_coupled_port_addr_i, sahb_addr_i} = '0;
    fahb_agent_i = 2'h1;
    sahb_agent_i = 2'h2;
    data_coupled_port_byte_lane_strobes_i = 8'hFF;
    sahb_byte_lane_strobes_i = 4'hF;
    clr;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_dummy;
    t_instr_coupled_port;
    t_fahb;
    t_sram;
    wrap_up;
  end
endmodule
bind maeh_top maeh_chk chk (.*);
`default_nettype wire
